/* logic/aoc_pkg.sv */
// Package with register map, field layout and decoded control types for the converter configuration block.
package aoc_pkg;

    // ************************************************************
    // Link frame layout
    // ************************************************************
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
    localparam logic [4:0] FRAME_DONE_CNT = 5'h18;

    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
    } aoc_frame_t;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_OUTPUT_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_EXTENDED_FEATURES_CONFIG = 8'h02;
    localparam logic [7:0] ADDR_CH0_OFFSET = 8'h03;
    localparam logic [7:0] ADDR_CH0_FULL_SCALE = 8'h04;
    localparam logic [7:0] ADDR_CH1_OFFSET = 8'h05;
    localparam logic [7:0] ADDR_CH1_FULL_SCALE = 8'h06;
    localparam logic [7:0] ADDR_PHASE_ADJUST = 8'h07;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int OC_DUAL_CLOCK_OUT_N = 0;
    localparam int OC_DUTY_STABILIZER_EN = 1;
    localparam int OC_DDR_CLOCK_PHASE = 2;
    localparam int OC_DDR_DISABLE = 3;
    localparam int OC_OUTPUT_SWING_SEL = 4;
    localparam int OC_EDGE_DEMUX_SEL = 5;
    localparam int EC_TEST_PATTERN_EN = 0;
    localparam int EC_TRIM_SKIP = 1;
    localparam int EC_LOW_RATE_BOOST = 2;
    localparam int OFS_SIGN = 15;
    localparam int OFS_MAG_LSB = 0;
    localparam int PA_INVERT = 15;
    localparam int PA_MID_LSB = 12;
    localparam int PA_COARSE_LSB = 4;
    localparam int PA_FINE_LSB = 0;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [15:0] OUTPUT_CONFIG_RST = 16'h0012;
    localparam logic [15:0] EXTENDED_FEATURES_CONFIG_RST = 16'h0000;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [9:0] FULL_SCALE_RST_MV = 10'h2BC;
    localparam logic [15:0] PHASE_ADJUST_RST = 16'h0000;

    // ************************************************************
    // Analog limits
    // ************************************************************
    localparam logic [9:0] FULL_SCALE_MIN_MV = 10'h230;
    localparam logic [9:0] FULL_SCALE_MAX_MV = 10'h348;
    localparam logic [11:0] MID_STEP_PS = 12'h00B;
    localparam logic [11:0] COARSE_STEP_PS = 12'h008;
    localparam logic [11:0] DELAY_MAX_PS = 12'h834;

    typedef struct packed {
        logic extended_mode;
        logic dual_clk_out_en;
        logic overrange_en;
        logic duty_stabilizer_en;
        logic ddr_mode;
        logic clk_phase_90;
        logic sdr_rising_edge;
        logic demux_mode;
        logic swing_normal;
        logic test_pattern_en;
        logic converter_cal;
        logic resistor_trim;
        logic out_clk_enable;
        logic low_rate_boost;
    } aoc_ctrl_t;

    typedef struct packed {
        logic offset_negative;
        logic [7:0] offset_mag;
        logic [9:0] full_scale_mv;
    } aoc_chan_t;

    typedef struct packed {
        logic sample_clock_invert;
        logic [11:0] total_ps;
        logic [3:0] fine_code;
    } aoc_delay_t;

endpackage

/* logic/aoc_config_regs.sv */
// Configuration register bank with serial link front end and decoded converter controls.
`timescale 1ns/1ps

// What this block does
// R01 - Clock-count bit 1 gives one output clock plus overrange; 0 gives two clocks.
// R02 - Duty stabilizer bit enables or disables input clock duty-cycle stabilization.
// R03 - In DDR only, phase bit selects 0 or 90 degree clock placement.
// R04 - DDR-disable 0 gives a word per edge; 1 gives one word per clock.
// R05 - Swing bit 1 selects normal output amplitude, 0 reduced amplitude.
// R06 - In SDR, edge bit 1 changes data on rising edge, 0 on falling.
// R07 - In DDR, edge bit 1 selects non-demultiplexed, 0 demultiplexed output.
// R08 - DDR with non-demultiplexed output forces 0 degree clock phase.
// R09 - Settings take effect only when the host writes that register.
// R10 - Test pattern bit replaces converter data on all outputs, overrange included.
// R11 - Test pattern works in SDR, DDR and non-demultiplexed modes alike.
// R12 - Trim-skip keeps resistor untrimmed and output clock enabled during calibration.
// R13 - Converter calibration always runs whatever the trim-skip bit says.
// R14 - Low-rate bit enables the mode for input clocks below 900 MHz.
// R15 - Host gives each channel offset as sign plus 8-bit magnitude.
// R16 - Per-channel full scale spans 560 to 840 mV, default 700 mV.
// R17 - Host recalibrates after any full-scale change.
// R18 - Polarity bit inverts the sampling clock.
// R19 - Each intermediate phase step adds about 11 ps; zero adds none.
// R20 - Coarse plus intermediate delay reaches about 2.1 ns; fine adds more.
// R21 - Host recalibrates after temperature or sampling mode changes.
// R22 - Register writes take effect only in extended control mode, set by the jumper.
// R23 - Second channel offset and full scale behave exactly like the first.
module aoc_config_regs (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic link_clk_in,
    input wire logic link_sel_n_in,
    input wire logic link_data_in,
    input wire logic extended_control_jumper_n_in,
    input wire logic edge_select_pin_in,
    input wire logic swing_select_pin_in,
    input wire logic cal_busy_in,
    output aoc_pkg::aoc_ctrl_t ctrl_out,
    output aoc_pkg::aoc_chan_t ch0_out,
    output aoc_pkg::aoc_chan_t ch1_out,
    output aoc_pkg::aoc_delay_t delay_out
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Out-of-range full-scale requests are clamped rather than refused.
    function automatic logic [9:0] fs_clamp(input logic [15:0] v);
        logic [9:0] r;
        r = v[9:0];
        if (v > {6'h00, aoc_pkg::FULL_SCALE_MAX_MV}) begin
            r = aoc_pkg::FULL_SCALE_MAX_MV;
        end else if (v < {6'h00, aoc_pkg::FULL_SCALE_MIN_MV}) begin
            r = aoc_pkg::FULL_SCALE_MIN_MV;
        end
        return r;
    endfunction

    function automatic aoc_pkg::aoc_chan_t chan_decode(input logic [15:0] ofs, input logic [9:0] fs);
        aoc_pkg::aoc_chan_t c;
        c.offset_negative = ofs[aoc_pkg::OFS_SIGN];
        c.offset_mag = ofs[aoc_pkg::OFS_MAG_LSB +: 8];
        c.full_scale_mv = fs;
        return c;
    endfunction

    // ************************************************************
    // Link domain: frame shifter
    // ************************************************************
    // The link clock only runs inside a frame, so the bit count is cleared by the select line itself.
    logic link_rst_n;
    logic [4:0] bit_cnt_q;
    logic [aoc_pkg::FRAME_BITS-2:0] shift_q;
    aoc_pkg::aoc_frame_t frame_q;
    logic frame_tog_q;

    assign link_rst_n = nrst_in & ~link_sel_n_in;

    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= 5'h00;
            shift_q <= '0;
        end else if (bit_cnt_q != aoc_pkg::FRAME_DONE_CNT) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            shift_q <= {shift_q[aoc_pkg::FRAME_BITS-3:0], link_data_in};
        end
    end

    // Frame word and toggle survive the end of the frame; the word holds still until the next frame completes.
    always_ff @(posedge link_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            frame_q <= '0;
            frame_tog_q <= 1'b0;
        end else if (!link_sel_n_in && bit_cnt_q == aoc_pkg::FRAME_LAST_BIT) begin
            frame_q <= {shift_q, link_data_in};
            frame_tog_q <= ~frame_tog_q;
        end
    end

    // ************************************************************
    // Crossing into the reference clock domain
    // ************************************************************
    logic [1:0] tog_sync_q;
    logic tog_seen_q;
    logic [1:0] jumper_sync_q;
    logic [1:0] edge_sync_q;
    logic [1:0] swing_sync_q;
    logic write_stb;
    logic ext_mode;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tog_sync_q <= 2'h0;
            tog_seen_q <= 1'b0;
            jumper_sync_q <= 2'h3;
            edge_sync_q <= 2'h0;
            swing_sync_q <= 2'h0;
        end else begin
            tog_sync_q <= {tog_sync_q[0], frame_tog_q};
            tog_seen_q <= tog_sync_q[1];
            jumper_sync_q <= {jumper_sync_q[0], extended_control_jumper_n_in};
            edge_sync_q <= {edge_sync_q[0], edge_select_pin_in};
            swing_sync_q <= {swing_sync_q[0], swing_select_pin_in};
        end
    end

    // R22 jumper gates writes
    assign ext_mode = ~jumper_sync_q[1];
    assign write_stb = (tog_sync_q[1] ^ tog_seen_q) & ext_mode;

    // ************************************************************
    // Register bank
    // ************************************************************
    logic [15:0] output_config_q;
    logic [15:0] extended_features_config_q;
    logic [15:0] ch0_offset_q;
    logic [15:0] ch1_offset_q;
    logic [9:0] ch0_full_scale_q;
    logic [9:0] ch1_full_scale_q;
    logic [15:0] phase_adjust_q;

    // R09 apply on write
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            output_config_q <= aoc_pkg::OUTPUT_CONFIG_RST;
            extended_features_config_q <= aoc_pkg::EXTENDED_FEATURES_CONFIG_RST;
            ch0_offset_q <= aoc_pkg::OFFSET_RST;
            ch1_offset_q <= aoc_pkg::OFFSET_RST;
            ch0_full_scale_q <= aoc_pkg::FULL_SCALE_RST_MV;
            ch1_full_scale_q <= aoc_pkg::FULL_SCALE_RST_MV;
            phase_adjust_q <= aoc_pkg::PHASE_ADJUST_RST;
        end else if (write_stb) begin
            unique case (frame_q.addr)
                aoc_pkg::ADDR_OUTPUT_CONFIG: begin
                    output_config_q <= frame_q.data;
                end
                aoc_pkg::ADDR_EXTENDED_FEATURES_CONFIG: begin
                    extended_features_config_q <= frame_q.data;
                end
                // R15 sign and magnitude
                aoc_pkg::ADDR_CH0_OFFSET: begin
                    ch0_offset_q <= frame_q.data;
                end
                // R16 full scale range
                aoc_pkg::ADDR_CH0_FULL_SCALE: begin
                    ch0_full_scale_q <= fs_clamp(frame_q.data);
                end
                // R23 second channel alike
                aoc_pkg::ADDR_CH1_OFFSET: begin
                    ch1_offset_q <= frame_q.data;
                end
                aoc_pkg::ADDR_CH1_FULL_SCALE: begin
                    ch1_full_scale_q <= fs_clamp(frame_q.data);
                end
                aoc_pkg::ADDR_PHASE_ADJUST: begin
                    phase_adjust_q <= frame_q.data;
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Control decode
    // ************************************************************
    aoc_pkg::aoc_ctrl_t ctrl_d;
    aoc_pkg::aoc_delay_t delay_d;
    logic edge_bit;
    logic [11:0] delay_sum;

    always_comb begin
        // Outside extended mode the edge and swing come from their pins.
        edge_bit = ext_mode ? output_config_q[aoc_pkg::OC_EDGE_DEMUX_SEL] : edge_sync_q[1];
        ctrl_d.extended_mode = ext_mode;
        // R01 clock count
        ctrl_d.dual_clk_out_en = ~output_config_q[aoc_pkg::OC_DUAL_CLOCK_OUT_N];
        ctrl_d.overrange_en = output_config_q[aoc_pkg::OC_DUAL_CLOCK_OUT_N];
        // R02 duty stabilizer
        ctrl_d.duty_stabilizer_en = output_config_q[aoc_pkg::OC_DUTY_STABILIZER_EN];
        // R04 data rate
        ctrl_d.ddr_mode = ~output_config_q[aoc_pkg::OC_DDR_DISABLE];
        // R06 SDR edge
        ctrl_d.sdr_rising_edge = ~ctrl_d.ddr_mode & edge_bit;
        // R07 demux select
        ctrl_d.demux_mode = ctrl_d.ddr_mode & ~edge_bit;
        // R03 R08 clock phase
        ctrl_d.clk_phase_90 = ctrl_d.demux_mode & output_config_q[aoc_pkg::OC_DDR_CLOCK_PHASE];
        // R05 output swing
        ctrl_d.swing_normal = ext_mode ? output_config_q[aoc_pkg::OC_OUTPUT_SWING_SEL] : swing_sync_q[1];
        // R10 R11 test pattern
        ctrl_d.test_pattern_en = extended_features_config_q[aoc_pkg::EC_TEST_PATTERN_EN];
        // R13 calibration always
        ctrl_d.converter_cal = cal_busy_in;
        // R12 trim skip
        ctrl_d.resistor_trim = cal_busy_in & ~extended_features_config_q[aoc_pkg::EC_TRIM_SKIP];
        ctrl_d.out_clk_enable = ~ctrl_d.resistor_trim;
        // R14 low rate boost
        ctrl_d.low_rate_boost = extended_features_config_q[aoc_pkg::EC_LOW_RATE_BOOST];
    end

    always_comb begin
        // R19 R20 delay sum
        delay_sum = 12'({4'h0, phase_adjust_q[aoc_pkg::PA_COARSE_LSB +: 8]} * aoc_pkg::COARSE_STEP_PS)
                  + 12'({9'h000, phase_adjust_q[aoc_pkg::PA_MID_LSB +: 3]} * aoc_pkg::MID_STEP_PS);
        // R18 clock invert
        delay_d.sample_clock_invert = phase_adjust_q[aoc_pkg::PA_INVERT];
        delay_d.total_ps = (delay_sum > aoc_pkg::DELAY_MAX_PS) ? aoc_pkg::DELAY_MAX_PS : delay_sum;
        delay_d.fine_code = phase_adjust_q[aoc_pkg::PA_FINE_LSB +: 4];
    end

    // ************************************************************
    // Output flops
    // ************************************************************
    // Registered so the analog side never sees decode glitches when a write lands.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_out <= '0;
            ch0_out <= '0;
            ch1_out <= '0;
            delay_out <= '0;
        end else begin
            ctrl_out <= ctrl_d;
            ch0_out <= chan_decode(ch0_offset_q, ch0_full_scale_q);
            ch1_out <= chan_decode(ch1_offset_q, ch1_full_scale_q);
            delay_out <= delay_d;
        end
    end

endmodule // aoc_config_regs

/* dv/aoc_config_regs_chk.sv */
// Checker with concurrent assertions on the outputs of the configuration register bank.
`timescale 1ns/1ps
module aoc_config_regs_chk (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic link_sel_n_in,
    input wire logic cal_busy_in,
    input aoc_pkg::aoc_ctrl_t ctrl_out,
    input aoc_pkg::aoc_chan_t ch0_out,
    input aoc_pkg::aoc_chan_t ch1_out,
    input aoc_pkg::aoc_delay_t delay_out
);
    // Outputs jump from all zero to decoded reset values on the first edge, so two edges are skipped.
    logic [1:0] live_q;
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            live_q <= 2'h0;
        end else begin
            live_q <= {live_q[0], 1'b1};
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!live_q[1]);
    // ************************************************************
    // Assertions
    // ************************************************************
    sequence sel_idle;
        link_sel_n_in [*6];
    endsequence
    clock_count_a: assert property (ctrl_out.dual_clk_out_en != ctrl_out.overrange_en)
        else $error("clock count and overrange disagree");
    phase_sdr_a: assert property (!ctrl_out.ddr_mode |-> !ctrl_out.clk_phase_90)
        else $error("quarter phase set in single rate mode");
    phase_nondemux_a: assert property (ctrl_out.ddr_mode && !ctrl_out.demux_mode |-> !ctrl_out.clk_phase_90)
        else $error("quarter phase set in non demultiplexed mode");
    trim_cal_a: assert property (ctrl_out.resistor_trim |-> ctrl_out.converter_cal)
        else $error("resistor trim outside calibration");
    clk_enable_a: assert property (ctrl_out.out_clk_enable == !ctrl_out.resistor_trim)
        else $error("output clock enable wrong during trim");
    cal_follow_a: assert property (ctrl_out.converter_cal == $past(cal_busy_in))
        else $error("converter calibration does not follow busy");
    range_fs_a: assert property (ch0_out.full_scale_mv >= aoc_pkg::FULL_SCALE_MIN_MV &&
        ch0_out.full_scale_mv <= aoc_pkg::FULL_SCALE_MAX_MV && ch1_out.full_scale_mv >= aoc_pkg::FULL_SCALE_MIN_MV &&
        ch1_out.full_scale_mv <= aoc_pkg::FULL_SCALE_MAX_MV) else $error("full scale out of range");
    delay_max_a: assert property (delay_out.total_ps <= aoc_pkg::DELAY_MAX_PS)
        else $error("delay above maximum");
    hold_idle_a: assert property (sel_idle |-> $stable({ch0_out, ch1_out, delay_out}))
        else $error("settings changed without a write");
endmodule // aoc_config_regs_chk

bind aoc_config_regs aoc_config_regs_chk u_chk (.ref_clk_in, .nrst_in, .link_sel_n_in, .cal_busy_in,
    .ctrl_out, .ch0_out, .ch1_out, .delay_out);

/* dv/aoc_host_model.sv */
// Host controller model that writes configuration frames over the serial link.
`timescale 1ns/1ps
module aoc_host_model (
    output logic link_clk_out,
    output logic link_sel_n_out,
    output logic link_data_out
);
    initial begin
        link_clk_out = 1'b0;
        link_sel_n_out = 1'b1;
        link_data_out = 1'b0;
    end
    // explicit group write
    // The link clock stands still between frames; a short count n gives a truncated frame.
    task automatic send_bits(input aoc_pkg::aoc_frame_t f, input int n);
        #3.7;
        link_sel_n_out = 1'b0;
        for (int i = aoc_pkg::FRAME_BITS - 1; i >= aoc_pkg::FRAME_BITS - n; i--) begin
            link_data_out = f[i];
            #62.5 link_clk_out = 1'b1;
            #62.5 link_clk_out = 1'b0;
        end
        #40.0 link_sel_n_out = 1'b1;
        // A released line shows the inverse so a stale bit cannot pass for data.
        link_data_out = ~link_data_out;
    endtask
endmodule // aoc_host_model

/* dv/test_aoc_config_regs.sv */
// Self-checking bench for the converter configuration register bank.
`timescale 1ns/1ps
module test_aoc_config_regs;
    logic clk, nrst, lclk, lsel_n, ldat, jmp_n, edge_pin, swing_pin, busy;
    aoc_pkg::aoc_ctrl_t ctrl;
    aoc_pkg::aoc_chan_t ch0, ch1;
    aoc_pkg::aoc_delay_t dly;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 32'h86907939;
    logic [15:0] oc, ec, r;
    logic [9:0] fs, fx;
    logic [11:0] tot;
    aoc_host_model u_host (.link_clk_out(lclk), .link_sel_n_out(lsel_n), .link_data_out(ldat));
    aoc_config_regs u_dut (.ref_clk_in(clk), .nrst_in(nrst), .link_clk_in(lclk), .link_sel_n_in(lsel_n),
        .link_data_in(ldat), .extended_control_jumper_n_in(jmp_n), .edge_select_pin_in(edge_pin),
        .swing_select_pin_in(swing_pin), .cal_busy_in(busy), .ctrl_out(ctrl), .ch0_out(ch0), .ch1_out(ch1),
        .delay_out(dly));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    function automatic logic [9:0] exp_fs(input logic [9:0] v);
        return (v < aoc_pkg::FULL_SCALE_MIN_MV) ? aoc_pkg::FULL_SCALE_MIN_MV :
            (v > aoc_pkg::FULL_SCALE_MAX_MV) ? aoc_pkg::FULL_SCALE_MAX_MV : v;
    endfunction
    function automatic logic [11:0] exp_tot(input logic [15:0] p);
        logic [11:0] t;
        t = 12'(p[11:4]) * aoc_pkg::COARSE_STEP_PS + 12'(p[14:12]) * aoc_pkg::MID_STEP_PS;
        return (t > aoc_pkg::DELAY_MAX_PS) ? aoc_pkg::DELAY_MAX_PS : t;
    endfunction
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
        u_host.send_bits({a, d}, n);
        repeat (8) @(negedge clk);
    endtask
    task automatic check_cfg();
        check(ctrl.extended_mode, 1'b1);
        check(ctrl.overrange_en, oc[0]);
        check(ctrl.dual_clk_out_en, !oc[0]);
        check(ctrl.duty_stabilizer_en, oc[1]);
        check(ctrl.ddr_mode, !oc[3]);
        check(ctrl.clk_phase_90, !oc[3] & !oc[5] & oc[2]);
        check(ctrl.swing_normal, oc[4]);
        if (!oc[3]) begin
            check(ctrl.demux_mode, !oc[5]);
        end else begin
            check(ctrl.sdr_rising_edge, oc[5]);
        end
        check(ctrl.test_pattern_en, ec[0]);
        check(ctrl.low_rate_boost, ec[2]);
        check(ctrl.resistor_trim, busy & !ec[1]);
        check(ctrl.out_clk_enable, !(busy & !ec[1]));
        check(ctrl.converter_cal, busy);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        nrst = 1'b0;
        jmp_n = 1'b0;
        edge_pin = 1'b0;
        swing_pin = 1'b0;
        busy = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        oc = aoc_pkg::OUTPUT_CONFIG_RST;
        ec = aoc_pkg::EXTENDED_FEATURES_CONFIG_RST;
        check_cfg();
        check(ch0, {9'h000, aoc_pkg::FULL_SCALE_RST_MV});
        check(ch1, {9'h000, aoc_pkg::FULL_SCALE_RST_MV});
        check(dly, 32'h00000000);
        for (int i = 0; i < 64; i++) begin
            oc = 16'(i);
            ec = 16'($random(seed));
            busy = 1'($random(seed));
            wr(aoc_pkg::ADDR_OUTPUT_CONFIG, oc, 24);
            wr(aoc_pkg::ADDR_EXTENDED_FEATURES_CONFIG, ec, 24);
            check_cfg();
        end
        wr(aoc_pkg::ADDR_OUTPUT_CONFIG, ~oc, 16);
        wr(8'h00, ~oc, 24);
        wr(8'h08, ~oc, 24);
        check_cfg();
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 6; k++) begin
                r = 16'($random(seed)) & 16'h80FF;
                fs = (k == 0) ? 10'h22F : (k == 1) ? 10'h349 : (k == 2) ? 10'h230 : (k == 3) ? 10'h348 :
                    10'h230 + 10'(r[7:0]);
                fx = exp_fs(fs);
                wr(c ? aoc_pkg::ADDR_CH1_OFFSET : aoc_pkg::ADDR_CH0_OFFSET, r, 24);
                wr(c ? aoc_pkg::ADDR_CH1_FULL_SCALE : aoc_pkg::ADDR_CH0_FULL_SCALE, {6'h00, fs}, 24);
                busy = 1'b1;
                repeat (3) @(negedge clk);
                busy = 1'b0;
                check(c ? ch1 : ch0, {r[15], r[7:0], fx});
            end
        end
        for (int k = 0; k < 8; k++) begin
            r = (k == 0) ? 16'h7FF3 : (k == 1) ? 16'h5FF0 : (k == 2) ? 16'h8010 : 16'($random(seed));
            wr(aoc_pkg::ADDR_PHASE_ADJUST, r, 24);
            tot = exp_tot(r);
            check(dly, {r[15], tot, r[3:0]});
        end
        jmp_n = 1'b1;
        wr(aoc_pkg::ADDR_PHASE_ADJUST, ~r, 24);
        check(dly, {r[15], tot, r[3:0]});
        check(ctrl.extended_mode, 1'b0);
        check(ctrl.swing_normal, swing_pin);
        check(ctrl.sdr_rising_edge, edge_pin);
        edge_pin = 1'b1;
        swing_pin = 1'b1;
        repeat (4) @(negedge clk);
        check(ctrl.swing_normal, swing_pin);
        check(ctrl.sdr_rising_edge, edge_pin);
        give_verdict();
    end
endmodule // test_aoc_config_regs
